// [pcsd_pkg.sv]
// Constants shared by the port chip-select decoder files.
`default_nettype none
package pcsd_pkg;
  // ---------------------------------------------------------------
  // Register addresses on the special function register bus
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_POLARITY  = 8'hAE;
  localparam logic [7:0] ADDR_CFG_LOW   = 8'hC2;
  localparam logic [7:0] ADDR_CFG_HIGH  = 8'hC3;
  localparam logic [7:0] ADDR_PORT_DATA = 8'hD8;
  localparam logic [7:0] ADDR_P0_BASE_L = 8'h84;
  localparam logic [7:0] ADDR_P0_BASE_H = 8'h85;
  localparam logic [7:0] ADDR_P1_BASE_L = 8'h94;
  localparam logic [7:0] ADDR_P1_BASE_H = 8'h95;
  localparam logic [7:0] ADDR_P2_BASE_L = 8'hAC;
  localparam logic [7:0] ADDR_P2_BASE_H = 8'hAD;
  localparam logic [7:0] ADDR_P3_BASE_L = 8'hB4;
  localparam logic [7:0] ADDR_P3_BASE_H = 8'hB5;
  // ---------------------------------------------------------------
  // Reset values and field layout
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_PORT_DATA  = 8'hFF;
  localparam logic [7:0] RST_ZERO       = 8'h00;
  localparam logic [3:0] RST_PINS       = 4'hF;
  localparam logic [7:0] POLARITY_MASK  = 8'hFC;
  localparam int         POL_LSB        = 4;
  localparam int         NUM_PINS       = 4;
  localparam int         FIELD_W        = 2;
  localparam int         BASE_W         = 16;

  typedef enum logic [1:0] {
    PCSD_FN_GPIO  = 2'b00,
    PCSD_FN_READ  = 2'b01,
    PCSD_FN_WRITE = 2'b10,
    PCSD_FN_BOTH  = 2'b11
  } pcsd_func_t;

  typedef enum logic [1:0] {
    PCSD_LEN_16 = 2'b00,
    PCSD_LEN_15 = 2'b01,
    PCSD_LEN_14 = 2'b10,
    PCSD_LEN_8  = 2'b11
  } pcsd_len_t;
endpackage : pcsd_pkg
`default_nettype wire

// [pcsd_cfg_if.sv]
// Per-pin configuration carried from the register file to the decoder.
`timescale 1ns/10ps
`default_nettype none
interface pcsd_cfg_if;
  logic [3:0][1:0]  func;
  logic [3:0][1:0]  matchLen;
  logic [3:0]       activeHigh;
  logic [3:0][15:0] base;
  logic [3:0]       strobe;

  modport regs (output func, output matchLen, output activeHigh,
                output base);
  modport dec  (input func, input matchLen, input activeHigh,
                input base, output strobe);
endinterface : pcsd_cfg_if
`default_nettype wire

// [pcsd_strobe_dec.sv]
// Address compare and strobe generation for the four port pins.
`timescale 1ns/10ps
`default_nettype none
module pcsd_strobe_dec (
  input  wire logic  [15:0] busAddr,
  input  wire logic         busRead,
  input  wire logic         busWrite,
  pcsd_cfg_if.dec           cfg
);
  // -------------------------------------------------------------
  // One comparator per pin
  // -------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < pcsd_pkg::NUM_PINS; i++) begin : gPin
      logic [15:0] careMask;
      logic        hit;
      logic        rdSel;
      logic        wrSel;
      assign careMask =
        (cfg.matchLen[i] == pcsd_pkg::PCSD_LEN_16) ? 16'hFFFF :
        (cfg.matchLen[i] == pcsd_pkg::PCSD_LEN_15) ? 16'hFFFE :
        (cfg.matchLen[i] == pcsd_pkg::PCSD_LEN_14) ? 16'hFFFC :
                                                     16'hFF00;
      assign hit = ((busAddr ^ cfg.base[i]) & careMask) == 16'h0000;
      assign rdSel = cfg.func[i] == pcsd_pkg::PCSD_FN_READ
                  || cfg.func[i] == pcsd_pkg::PCSD_FN_BOTH;
      assign wrSel = cfg.func[i] == pcsd_pkg::PCSD_FN_WRITE
                  || cfg.func[i] == pcsd_pkg::PCSD_FN_BOTH;
      // Active in the same cycle as the bus strobe it follows.
      assign cfg.strobe[i] = hit && ((rdSel && busRead)
                                  || (wrSel && busWrite));
    end
  endgenerate
endmodule // pcsd_strobe_dec
`default_nettype wire

// [pcsd_port.sv]
// Four-pin port with general output and address-decoded chip selects.
//
// Function
// - Function 00 drives pin from data bit.
// - Function 01 strobes on matching reads.
// - Function 10 strobes on matching writes.
// - Function 11 strobes on reads and writes.
// - Length 00 compares all sixteen address bits.
// - Length 01 ignores address bit 0.
// - Length 10 ignores address bits 1:0.
// - Length 11 ignores low address byte.
// - High config holds pins 3 and 2.
// - Low config holds pins 1 and 0.
// - Pin 3 polarity bit 7, one active high.
// - Bits 6:4 set polarity, pins 2 to 0.
// - Base address split in high/low bytes.
// - Data bits 3:0 drive general pins.
// - Matching write pulses a write strobe pin.
// - Strobe pin trails bus read/write signal by one clock.
`timescale 1ns/10ps
`default_nettype none
module pcsd_port (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       sfrWrite,
  input  wire logic       sfrRead,
  input  wire logic [7:0] sfrAddr,
  input  wire logic [7:0] sfrWdata,
  output logic      [7:0] sfrRdata,
  input  wire logic [15:0] busAddr,
  input  wire logic       busRead,
  input  wire logic       busWrite,
  output logic      [3:0] portPin
);
  // -------------------------------------------------------------
  // Register file
  // -------------------------------------------------------------
  logic [7:0] polarity_reg;
  logic [7:0] cfgLow_reg;
  logic [7:0] cfgHigh_reg;
  logic [7:0] portData_reg;
  logic [7:0] baseLow_reg  [4];
  logic [7:0] baseHigh_reg [4];
  logic [7:0] sfrRdata_next;
  logic [3:0] portPin_next;
  logic       wrPol;
  logic       wrCfgL;
  logic       wrCfgH;
  logic       wrData;

  pcsd_cfg_if cfg ();

  assign wrPol  = sfrWrite && sfrAddr == pcsd_pkg::ADDR_POLARITY;
  assign wrCfgL = sfrWrite && sfrAddr == pcsd_pkg::ADDR_CFG_LOW;
  assign wrCfgH = sfrWrite && sfrAddr == pcsd_pkg::ADDR_CFG_HIGH;
  assign wrData = sfrWrite && sfrAddr == pcsd_pkg::ADDR_PORT_DATA;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      polarity_reg <= pcsd_pkg::RST_ZERO;
      cfgLow_reg   <= pcsd_pkg::RST_ZERO;
      cfgHigh_reg  <= pcsd_pkg::RST_ZERO;
      portData_reg <= pcsd_pkg::RST_PORT_DATA;
    end else begin
      if (wrPol)
        polarity_reg <= sfrWdata & pcsd_pkg::POLARITY_MASK;
      if (wrCfgL)
        cfgLow_reg <= sfrWdata;
      if (wrCfgH)
        cfgHigh_reg <= sfrWdata;
      if (wrData)
        portData_reg <= sfrWdata;
    end
  end

  // Base byte addresses differ per pin, so they are listed in a table.
  localparam logic [7:0] BASE_L_ADDR [4] = '{pcsd_pkg::ADDR_P0_BASE_L,
    pcsd_pkg::ADDR_P1_BASE_L, pcsd_pkg::ADDR_P2_BASE_L,
    pcsd_pkg::ADDR_P3_BASE_L};
  localparam logic [7:0] BASE_H_ADDR [4] = '{pcsd_pkg::ADDR_P0_BASE_H,
    pcsd_pkg::ADDR_P1_BASE_H, pcsd_pkg::ADDR_P2_BASE_H,
    pcsd_pkg::ADDR_P3_BASE_H};

  genvar p;
  generate
    for (p = 0; p < pcsd_pkg::NUM_PINS; p++) begin : gBase
      logic wrL;
      logic wrH;
      assign wrL = sfrWrite && sfrAddr == BASE_L_ADDR[p];
      assign wrH = sfrWrite && sfrAddr == BASE_H_ADDR[p];
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          baseLow_reg[p]  <= pcsd_pkg::RST_ZERO;
          baseHigh_reg[p] <= pcsd_pkg::RST_ZERO;
        end else begin
          if (wrL)
            baseLow_reg[p] <= sfrWdata;
          if (wrH)
            baseHigh_reg[p] <= sfrWdata;
        end
      end
      assign cfg.base[p] = {baseHigh_reg[p], baseLow_reg[p]};
      assign cfg.activeHigh[p] =
        polarity_reg[pcsd_pkg::POL_LSB + p];
    end
  endgenerate

  assign cfg.func[3]     = cfgHigh_reg[7:6];
  assign cfg.matchLen[3] = cfgHigh_reg[5:4];
  assign cfg.func[2]     = cfgHigh_reg[3:2];
  assign cfg.matchLen[2] = cfgHigh_reg[1:0];
  assign cfg.func[1]     = cfgLow_reg[7:6];
  assign cfg.matchLen[1] = cfgLow_reg[5:4];
  assign cfg.func[0]     = cfgLow_reg[3:2];
  assign cfg.matchLen[0] = cfgLow_reg[1:0];

  // -------------------------------------------------------------
  // Address decoder
  // -------------------------------------------------------------
  pcsd_strobe_dec uDec (
    .busAddr  (busAddr),
    .busRead  (busRead),
    .busWrite (busWrite),
    .cfg      (cfg.dec)
  );

  // -------------------------------------------------------------
  // Pin drivers
  // -------------------------------------------------------------
  // The pins are registered, so a strobe trails its bus signal by one
  // clock; the bus signals are expected to come from this clock domain.
  generate
    for (p = 0; p < pcsd_pkg::NUM_PINS; p++) begin : gPinOut
      assign portPin_next[p] =
        (cfg.func[p] == pcsd_pkg::PCSD_FN_GPIO) ? portData_reg[p]
        : (cfg.strobe[p] ~^ cfg.activeHigh[p]);
    end
  endgenerate

  always_comb begin
    case (sfrAddr)
      pcsd_pkg::ADDR_POLARITY:  sfrRdata_next = polarity_reg;
      pcsd_pkg::ADDR_CFG_LOW:   sfrRdata_next = cfgLow_reg;
      pcsd_pkg::ADDR_CFG_HIGH:  sfrRdata_next = cfgHigh_reg;
      pcsd_pkg::ADDR_PORT_DATA: sfrRdata_next = portData_reg;
      pcsd_pkg::ADDR_P0_BASE_L: sfrRdata_next = baseLow_reg[0];
      pcsd_pkg::ADDR_P0_BASE_H: sfrRdata_next = baseHigh_reg[0];
      pcsd_pkg::ADDR_P1_BASE_L: sfrRdata_next = baseLow_reg[1];
      pcsd_pkg::ADDR_P1_BASE_H: sfrRdata_next = baseHigh_reg[1];
      pcsd_pkg::ADDR_P2_BASE_L: sfrRdata_next = baseLow_reg[2];
      pcsd_pkg::ADDR_P2_BASE_H: sfrRdata_next = baseHigh_reg[2];
      pcsd_pkg::ADDR_P3_BASE_L: sfrRdata_next = baseLow_reg[3];
      pcsd_pkg::ADDR_P3_BASE_H: sfrRdata_next = baseHigh_reg[3];
      default:                  sfrRdata_next = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      portPin  <= pcsd_pkg::RST_PINS;
      sfrRdata <= pcsd_pkg::RST_ZERO;
    end else begin
      portPin  <= portPin_next;
      sfrRdata <= sfrRead ? sfrRdata_next : 8'h00;
    end
  end

  // -------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  gpio_pin_follow_a: assert property (
    cfg.func[0] == 2'b00 |=> portPin[0] == $past(portData_reg[0]))
    else $error("gpio pin 0 not driven from data bit");
  gpio_pin3_follow_a: assert property (
    cfg.func[3] == 2'b00 |=> portPin[3] == $past(portData_reg[3]))
    else $error("gpio pin 3 not driven from data bit");
  read_strobe_a: assert property (
    cfg.func[1] == 2'b01 && busRead && !busWrite
    && busAddr == cfg.base[1] |=> portPin[1] == $past(cfg.activeHigh[1]))
    else $error("read strobe missing on pin 1");
  write_strobe_a: assert property (
    cfg.func[0] == 2'b10 && busWrite && busAddr == cfg.base[0]
    |=> portPin[0] == $past(cfg.activeHigh[0]))
    else $error("write strobe missing on pin 0");
  write_ignores_read_a: assert property (
    cfg.func[2] == 2'b10 && !busWrite |=> portPin[2] != $past(cfg.activeHigh[2]))
    else $error("write strobe pin 2 active without write");
  both_strobe_a: assert property (
    cfg.func[3] == 2'b11 && (busRead || busWrite)
    && busAddr == cfg.base[3] |=> portPin[3] == $past(cfg.activeHigh[3]))
    else $error("read/write strobe missing on pin 3");
  len8_match_a: assert property (
    cfg.func[2] == 2'b11 && cfg.matchLen[2] == 2'b11 && busRead
    && busAddr[15:8] == cfg.base[2][15:8]
    |=> portPin[2] == $past(cfg.activeHigh[2]))
    else $error("byte-masked compare missed on pin 2");
  len16_miss_a: assert property (
    cfg.func[1] == 2'b11 && cfg.matchLen[1] == 2'b00
    && busAddr[0] != cfg.base[1][0]
    |=> portPin[1] != $past(cfg.activeHigh[1]))
    else $error("full compare matched wrong address on pin 1");
  len14_miss_a: assert property (
    cfg.func[0] != 2'b00 && cfg.matchLen[0] == 2'b10
    && busAddr[2] != cfg.base[0][2]
    |=> portPin[0] != $past(cfg.activeHigh[0]))
    else $error("14-bit compare matched wrong address on pin 0");
  pol_low_bits_a: assert property (
    polarity_reg[1:0] == 2'b00)
    else $error("polarity register low bits not zero");

  gpio_pin1_follow_a: assert property (
    cfg.func[1] == 2'b00 |=> portPin[1] == $past(portData_reg[1]))
    else $error("gpio pin 1 not driven from data bit");
  gpio_pin2_follow_a: assert property (
    cfg.func[2] == 2'b00 |=> portPin[2] == $past(portData_reg[2]))
    else $error("gpio pin 2 not driven from data bit");
  read_ignores_write_a: assert property (
    cfg.func[1] == 2'b01 && !busRead
    |=> portPin[1] != $past(cfg.activeHigh[1]))
    else $error("read strobe pin 1 active without read");
  len15_match_a: assert property (
    cfg.func[3] == 2'b11 && cfg.matchLen[3] == 2'b01
    && (busRead || busWrite) && busAddr[15:1] == cfg.base[3][15:1]
    |=> portPin[3] == $past(cfg.activeHigh[3]))
    else $error("15-bit compare missed on pin 3");
  len15_miss_a: assert property (
    cfg.func[3] != 2'b00 && cfg.matchLen[3] == 2'b01
    && busAddr[1] != cfg.base[3][1]
    |=> portPin[3] != $past(cfg.activeHigh[3]))
    else $error("15-bit compare matched wrong address on pin 3");
  len14_match_a: assert property (
    cfg.func[0] == 2'b10 && cfg.matchLen[0] == 2'b10 && busWrite
    && busAddr[15:2] == cfg.base[0][15:2]
    |=> portPin[0] == $past(cfg.activeHigh[0]))
    else $error("14-bit compare missed on pin 0");
  len8_miss_a: assert property (
    cfg.func[2] != 2'b00 && cfg.matchLen[2] == 2'b11
    && busAddr[8] != cfg.base[2][8]
    |=> portPin[2] != $past(cfg.activeHigh[2]))
    else $error("byte-masked compare matched wrong address on pin 2");
  idle_inactive_a: assert property (
    cfg.func[3] != 2'b00 && !busRead && !busWrite
    |=> portPin[3] != $past(cfg.activeHigh[3]))
    else $error("strobe pin 3 active while bus idle");
  pol_readback_a: assert property (
    sfrRead && sfrAddr == pcsd_pkg::ADDR_POLARITY
    |=> sfrRdata[1:0] == 2'b00)
    else $error("polarity register low bits read back nonzero");

  rd_strobe_c: cover property (cfg.func[1] == 2'b01 && cfg.strobe[1]);
  len8_strobe_c: cover property (cfg.func[2] != 2'b00
                                 && cfg.matchLen[2] == 2'b11
                                 && cfg.strobe[2]);
  gpio_low_c: cover property (cfg.func[0] == 2'b00 && portPin[0] == 1'b0);
  wr_strobe_c: cover property (cfg.func[0] == 2'b10 && cfg.strobe[0]);
  rw_strobe_c: cover property (cfg.func[3] == 2'b11 && cfg.strobe[3]
                               && cfg.activeHigh[3]);
endmodule // pcsd_port
`default_nettype wire

// [pcsd_periph_model.sv]
// Peripheral chips sitting on the port's strobe pins.
`timescale 1ns/10ps
`default_nettype none
module pcsd_periph_model (
  input  wire logic [3:0] portPin,
  input  wire logic [3:0] activeHigh,
  output logic      [3:0] selected
);
  // A chip is selected while its pin sits at the programmed active level.
  assign selected = ~(portPin ^ activeHigh);
endmodule // pcsd_periph_model
`default_nettype wire

// [pcsd_port_tb_top.sv]
// Self-checking testbench for the port chip-select decoder.
`timescale 1ns/10ps
`default_nettype none
module pcsd_port_tb_top;
  typedef struct {int cyc; bit rd; logic [7:0] exp;} pcsd_note_t;
  logic        sys_clk  = 1'b0;
  logic        reset    = 1'b1;
  logic        sfrWrite = 1'b0;
  logic        sfrRead  = 1'b0;
  logic [7:0]  sfrAddr  = 8'h00;
  logic [7:0]  sfrWdata = 8'h00;
  logic [15:0] busAddr  = 16'h0000;
  logic        busRead  = 1'b0;
  logic        busWrite = 1'b0;
  logic [7:0]  sfrRdata;
  logic [3:0]  portPin;
  logic [3:0]  selected;
  logic [7:0]  sh [256];
  logic [7:0]  regs [12];
  logic [15:0] m;
  logic [15:0] a;
  pcsd_note_t  q [$];
  int          errors = 0;
  int          check_count = 0;
  int          cyc = 0;

  always #20 sys_clk = ~sys_clk;

  pcsd_port i_pcsd_port (.sys_clk(sys_clk), .reset(reset),
    .sfrWrite(sfrWrite), .sfrRead(sfrRead), .sfrAddr(sfrAddr),
    .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .busAddr(busAddr),
    .busRead(busRead), .busWrite(busWrite), .portPin(portPin));
  pcsd_periph_model i_pcsd_periph_model (.portPin(portPin),
    .activeHigh(sh[8'hAE][7:4]), .selected(selected));

  // ----------------------------------------------------------------
  // Checking
  // ----------------------------------------------------------------
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  always @(posedge sys_clk) begin
    #1;
    cyc++;
    while (q.size() > 0 && q[0].cyc <= cyc) begin
      if (q[0].rd)
        check("sfrRdata", sfrRdata, q[0].exp);
      else
        check("pins", {selected, portPin}, q[0].exp);
      void'(q.pop_front());
    end
  end

  task automatic conclude();
    if (q.size() != 0)
      errors++;
    $display("comparisons %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  // Low nibble: expected pins; high nibble: expected peripheral selects.
  function automatic logic [7:0] exp_pins(logic [15:0] ba, bit r, bit w);
    logic [7:0]  c;
    logic [15:0] mk;
    logic        hit;
    exp_pins = 8'h00;
    for (int i = 0; i < 4; i++) begin
      c = (i < 2) ? sh[8'hC2] : sh[8'hC3];
      c = c >> ((i % 2) * 4);
      mk = (c[1:0] == 2'd3) ? 16'hFF00 : 16'hFFFF << c[1:0];
      hit = ((ba ^ {sh[regs[5+2*i]], sh[regs[4+2*i]]}) & mk) == 16'h0000;
      hit = hit && ((c[2] && r) || (c[3] && w));
      exp_pins[i] = (c[3:2] == 2'b00) ? sh[8'hD8][i]
                  : hit ~^ sh[8'hAE][4+i];
      exp_pins[4+i] = exp_pins[i] ~^ sh[8'hAE][4+i];
    end
  endfunction

  // Every input is assigned once per cycle, so back-to-back calls are safe.
  task automatic drive(bit w, bit r, logic [7:0] ad, logic [7:0] d,
                       logic [15:0] ba, bit br, bit bw);
    sfrWrite = w;
    sfrRead  = r;
    sfrAddr  = ad;
    sfrWdata = d;
    busAddr  = ba;
    busRead  = br;
    busWrite = bw;
    if (r) q.push_back('{cyc + 1, 1'b1, sh[ad]});
    if (!w && !r) q.push_back('{cyc + 1, 1'b0, exp_pins(ba, br, bw)});
    if (w) foreach (regs[k]) if (regs[k] == ad)
      sh[ad] = (ad == 8'hAE) ? (d & pcsd_pkg::POLARITY_MASK) : d;
    @(posedge sys_clk);
    #2;
  endtask

  task automatic wr(logic [7:0] ad, logic [7:0] d);
    drive(1'b1, 1'b0, ad, d, 16'h0000, 1'b0, 1'b0);
  endtask

  task automatic rd(logic [7:0] ad);
    drive(1'b0, 1'b1, ad, 8'h00, 16'h0000, 1'b0, 1'b0);
  endtask

  task automatic bus(logic [15:0] ba, bit br, bit bw);
    drive(1'b0, 1'b0, 8'h00, 8'h00, ba, br, bw);
  endtask

  initial begin
    repeat (5000) @(posedge sys_clk);
    errors++;
    conclude();
  end

  initial begin
    void'($urandom(16159));
    regs = '{8'hAE, 8'hC2, 8'hC3, 8'hD8, 8'h84, 8'h85,
             8'h94, 8'h95, 8'hAC, 8'hAD, 8'hB4, 8'hB5};
    foreach (sh[k]) sh[k] = 8'h00;
    sh[8'hD8] = pcsd_pkg::RST_PORT_DATA;
    repeat (8) @(posedge sys_clk);
    #2;
    reset = 1'b0;
    foreach (regs[k]) rd(regs[k]);
    rd(8'h01);
    foreach (regs[k]) wr(regs[k], 8'($urandom));
    wr(8'h01, 8'hA5);
    foreach (regs[k]) rd(regs[k]);
    rd(8'h01);
    wr(8'hC2, 8'h00);
    wr(8'hC3, 8'h00);
    repeat (4) begin
      wr(8'hD8, 8'($urandom));
      bus(16'($urandom), 1'b1, 1'b0);
      bus(16'($urandom), 1'b0, 1'b1);
    end
    for (int f = 1; f < 4; f++) begin
      for (int l = 0; l < 4; l++) begin
        wr(8'hC2, {f[1:0], l[1:0], f[1:0], l[1:0]});
        wr(8'hC3, {f[1:0], l[1:0], f[1:0], l[1:0]});
        foreach (regs[k]) if (k != 1 && k != 2 && k != 3)
          wr(regs[k], 8'($urandom));
        m = (l == 3) ? 16'hFF00 : 16'hFFFF << l;
        for (int i = 0; i < 4; i++) begin
          a = {sh[regs[5+2*i]], sh[regs[4+2*i]]} ^ (16'($urandom) & ~m);
          bus(a, 1'b1, 1'b0);
          bus(a, 1'b0, 1'b1);
          bus(a, 1'b0, 1'b0);
          bus(a ^ (~m + 16'h0001), 1'b1, 1'b0);
          bus(a ^ (~m + 16'h0001), 1'b0, 1'b1);
        end
      end
    end
    repeat (3) @(posedge sys_clk);
    conclude();
  end
endmodule // pcsd_port_tb_top
`default_nettype wire
